// ---- shared/cpg_consts.vh ----
/*
 Shared constants for the charger power-path and gate sequencer.
 Assumes a 250 MHz core clock; each time below is turned into clock cycles in the module that uses it.
*/
`ifndef CPG_CONSTS_VH
`define CPG_CONSTS_VH

// Clock rate in kHz and period in ns.
`define CPG_CLK_KHZ 250000
`define CPG_CLK_NS 4

// Selector timing: adapter qualify delay (ms) and break-before-make gap (us).
`define CPG_QUALIFY_MS 700
`define CPG_BBM_US 10

// Soft-start: number of steps and the hold time of each step (ms).
`define CPG_SS_STEPS 8
`define CPG_SS_STEP_MS 1

// Buck timing: switching frequency (kHz), dead time (ns), recharge pulse (ns).
`define CPG_FSW_KHZ 300
`define CPG_DEAD_NS 30
`define CPG_PULSE_NS 80

// Bootstrap-low periods tolerated before a forced refresh.
`define CPG_BOOT_LOW_MAX 3

// Selector states.
`define CPG_ST_BATT 3'h0
`define CPG_ST_TO_AC 3'h1
`define CPG_ST_AC 3'h2
`define CPG_ST_TO_BATT 3'h3

// Positions of the pin inputs in the synchroniser bank.
`define CPG_NSYNC 9
`define CPG_I_DET 0
`define CPG_I_SUPOK 1
`define CPG_I_NEAR 2
`define CPG_I_LEARN 3
`define CPG_I_PKLOW 4
`define CPG_I_CHGEN 5
`define CPG_I_BOOT 6
`define CPG_I_FALL 7
`define CPG_I_RISE 8

`endif

// ---- logic/cpg_gate_drive.v ----
/*
 Buck gate-drive timing: one fixed-frequency period counter, high-side on time,
 dead time, synchronous or pulsed low side, and bootstrap refresh cycles.
 Assumes run, syncMode and bootLow come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "cpg_consts.vh"

module cpg_gate_drive
(
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Control from the sequencer.
  input wire run,
  input wire syncMode,
  input wire bootLow,
  input wire [9:0] dutyReq,
  // Gate commands, high means the switch is driven on.
  output reg highSideGate_r,
  output reg lowSideGate_r
);

  // Period, dead time and pulse lengths in cycles, worked out at full integer width.
  localparam integer PERIOD_I = (`CPG_CLK_KHZ / `CPG_FSW_KHZ);
  localparam integer DEAD_I = ((`CPG_DEAD_NS + `CPG_CLK_NS - 1) / `CPG_CLK_NS);
  localparam integer PULSE_I = (`CPG_PULSE_NS / `CPG_CLK_NS);
  localparam integer BOOT_I = `CPG_BOOT_LOW_MAX;
  // The counts are then cut on purpose to the width of the counters they meet.
  localparam [9:0] PERIOD = PERIOD_I[9:0];
  localparam [9:0] DEAD = DEAD_I[9:0];
  localparam [9:0] PULSE = PULSE_I[9:0];
  localparam [1:0] BOOT_MAX = BOOT_I[1:0];

  reg [9:0] phase_r; // Position inside the switching period.
  reg [9:0] onTime_r; // High-side on time latched for this period.
  reg modeSync_r; // Mode latched for this period.
  reg refresh_r; // This period is a bootstrap recharge period.
  reg [1:0] bootCnt_r; // Consecutive periods that started with a low bootstrap.
  reg [9:0] lowStart; // First cycle of the low-side window.
  reg highNxt;
  reg lowNxt;

  // The period counter free-runs so the frequency never depends on the loop state.
  always @(posedge mclk)
  begin
    if (srst)
      phase_r <= 10'h000;
    else if (phase_r == PERIOD - 10'h001)
      phase_r <= 10'h000;
    else
      phase_r <= phase_r + 10'h001;
  end

  // Per-period decisions are taken only at the period start so a cycle never tears.
  always @(posedge mclk)
  begin
    if (srst)
    begin
      onTime_r <= 10'h000;
      modeSync_r <= 1'b0;
      refresh_r <= 1'b0;
      bootCnt_r <= 2'h0;
    end
    else if (phase_r == PERIOD - 10'h001)
    begin
      // A full request is clipped one cycle short, so the bootstrap still sees a gap.
      onTime_r <= (dutyReq >= PERIOD) ? PERIOD - 10'h001 : dutyReq;
      modeSync_r <= syncMode;
      if (!bootLow)
      begin
        bootCnt_r <= 2'h0;
        refresh_r <= 1'b0;
      end
      else if (!syncMode)
      begin
        // Pulsed mode with a weak bootstrap: only the recharge pulse this period.
        refresh_r <= 1'b1;
        bootCnt_r <= 2'h0;
      end
      else if (bootCnt_r == BOOT_MAX)
      begin
        // Low for more than the tolerated periods: force one recharge period.
        refresh_r <= 1'b1;
        bootCnt_r <= 2'h0;
      end
      else
      begin
        refresh_r <= 1'b0;
        bootCnt_r <= bootCnt_r + 2'h1;
      end
    end
  end

  // Gate windows for the current period.
  always @*
  begin
    lowStart = refresh_r ? DEAD : onTime_r + DEAD;
    highNxt = run && !refresh_r && (phase_r < onTime_r);
    if (!run)
      lowNxt = 1'b0;
    else if (modeSync_r && !refresh_r)
      lowNxt = (phase_r >= lowStart) && (phase_r < PERIOD - DEAD);
    else
      lowNxt = (phase_r >= lowStart) && (phase_r < lowStart + PULSE) &&
               (phase_r < PERIOD - DEAD);
  end

  // Registered gate outputs.
  always @(posedge mclk)
  begin
    if (srst)
    begin
      highSideGate_r <= 1'b0;
      lowSideGate_r <= 1'b0;
    end
    else
    begin
      highSideGate_r <= highNxt;
      lowSideGate_r <= lowNxt;
    end
  end

endmodule

// ---- logic/cpg_sequencer.v ----
/*
 Charger sequencer: power-path selector with break-before-make, learn override,
 charge enable with soft-start, sync-mode hysteresis and the buck gate driver.
 Assumes analog comparators deliver the threshold decisions as asynchronous
 logic levels; duty and programmed current come from logic on mclk.
*/
// What this block does
// - Adapter present once detect comparator trips.
// - No adapter: source gate off, pack on.
// - Move to adapter only after 700 ms.
// - Transfer needs supply 185 mV above pack.
// - Both off 10 us, then source on.
// - Adapter gone: wait near-pack, 10 us, battery.
// - Learn low: selector follows the adapter.
// - Learn high: battery feeds system, charging stops.
// - Pack below 2.9 V/cell ends learn for the selector only.
// - Charge target rises in 8 steps.
// - Buck switches at fixed 300 kHz.
// - High-side duty clipped below 100 percent.
// - Bootstrap low over 3 cycles forces recharge.
// - Low current runs non-synchronous, else synchronous.
// - Synchronous low side complementary, 30 ns dead.
// - Non-synchronous low side pulses 80 ns.
// - Weak bootstrap non-sync: only recharge pulse.
// - Sync comparator has falling trip and hysteresis.
`timescale 1ns/1ns
`include "cpg_consts.vh"

module cpg_sequencer
#(
  // Adapter qualify delay in cycles; shorten in simulation.
  parameter QUALIFY_CYC = `CPG_QUALIFY_MS * `CPG_CLK_KHZ,
  // Hold time of one soft-start step in cycles; shorten in simulation.
  parameter STEP_CYC = `CPG_SS_STEP_MS * `CPG_CLK_KHZ
)
(
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Asynchronous comparator levels and host pins.
  input wire sourceDetectAbove,
  input wire supplyAbovePack,
  input wire senseLowNearPack,
  input wire learnIn,
  input wire packBelowCellMin,
  input wire chargeEnableReq,
  input wire bootCapLow,
  input wire chargeSenseBelowFall,
  input wire chargeSenseAboveRise,
  // Same-clock values from the regulation logic.
  input wire [9:0] dutyReq,
  input wire [7:0] chargeCurrentProg,
  // Power-path switch gates, high means the switch is turned on.
  output reg sourceSwitchGate_r,
  output reg packSwitchGate_r,
  // Status.
  output reg adapterGood_r,
  output reg chargeOn_r,
  output reg syncMode_r,
  output reg [7:0] chargeTarget_r,
  // Buck gate commands.
  output wire highSideGate,
  output wire lowSideGate
);

  // Selector dead time in cycles, rounded up, at full integer width.
  localparam integer BBM_I =
    ((`CPG_BBM_US * 1000 + `CPG_CLK_NS - 1) / `CPG_CLK_NS);
  localparam integer QUALIFY_LAST_I = QUALIFY_CYC - 1;
  localparam integer STEP_LAST_I = STEP_CYC - 1;
  localparam integer SS_LAST_I = `CPG_SS_STEPS;
  // Counter widths cover the default counts with margin; the cut is deliberate.
  localparam [11:0] BBM_CYC = BBM_I[11:0];
  localparam [27:0] QUALIFY_LAST = QUALIFY_LAST_I[27:0];
  localparam [19:0] STEP_LAST = STEP_LAST_I[19:0];
  localparam [3:0] SS_LAST = SS_LAST_I[3:0];

  // Two-stage synchroniser bank for all asynchronous levels.
  wire [`CPG_NSYNC-1:0] pinRaw;
  reg [`CPG_NSYNC-1:0] meta_r; // First stage, read only by the second stage.
  reg [`CPG_NSYNC-1:0] pinSync_r; // Second stage, safe to use.

  assign pinRaw[`CPG_I_DET] = sourceDetectAbove;
  assign pinRaw[`CPG_I_SUPOK] = supplyAbovePack;
  assign pinRaw[`CPG_I_NEAR] = senseLowNearPack;
  assign pinRaw[`CPG_I_LEARN] = learnIn;
  assign pinRaw[`CPG_I_PKLOW] = packBelowCellMin;
  assign pinRaw[`CPG_I_CHGEN] = chargeEnableReq;
  assign pinRaw[`CPG_I_BOOT] = bootCapLow;
  assign pinRaw[`CPG_I_FALL] = chargeSenseBelowFall;
  assign pinRaw[`CPG_I_RISE] = chargeSenseAboveRise;

  // One synchroniser per input bit.
  genvar gi;
  generate
    for (gi = 0; gi < `CPG_NSYNC; gi = gi + 1)
    begin : gSync
      always @(posedge mclk)
      begin
        if (srst)
        begin
          meta_r[gi] <= 1'b0;
          pinSync_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= pinRaw[gi];
          pinSync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised levels.
  wire detected = pinSync_r[`CPG_I_DET];
  wire supplyOk = pinSync_r[`CPG_I_SUPOK];
  wire nearPack = pinSync_r[`CPG_I_NEAR];
  wire learn = pinSync_r[`CPG_I_LEARN];
  wire packLow = pinSync_r[`CPG_I_PKLOW];
  wire chargeReq = pinSync_r[`CPG_I_CHGEN];
  wire bootLow = pinSync_r[`CPG_I_BOOT];
  wire senseFall = pinSync_r[`CPG_I_FALL];
  wire senseRise = pinSync_r[`CPG_I_RISE];

  // Adapter qualify timer: restarts whenever detection drops.
  reg [27:0] qualCnt_r;
  reg qualified_r; // Adapter has been present for the full delay.

  // The delay runs only while the detect comparator stays high.
  always @(posedge mclk)
  begin
    if (srst)
    begin
      qualCnt_r <= 28'h0000000;
      qualified_r <= 1'b0;
    end
    else if (!detected)
    begin
      qualCnt_r <= 28'h0000000;
      qualified_r <= 1'b0;
    end
    else if (qualCnt_r == QUALIFY_LAST)
      qualified_r <= 1'b1;
    else
      qualCnt_r <= qualCnt_r + 28'h0000001;
  end

  // Selector state and dead-time counter.
  reg [2:0] selState_r;
  reg [2:0] selState_nxt;
  reg [11:0] bbmCnt_r;
  reg [11:0] bbmCnt_nxt;
  reg srcNxt;
  reg packNxt;
  reg learnHold; // Learn override is active and the pack is still healthy.
  reg goAdapter; // Conditions to move the load onto the adapter.
  reg goBattery; // Conditions to move the load back onto the pack.

  // Selector decisions and gate values for the next state.
  always @*
  begin
    // A depleted pack ends the learn override so the pack is protected.
    learnHold = learn && !packLow;
    goAdapter = qualified_r && supplyOk && !learnHold;
    // Removal waits for the input node to fall back near the pack.
    goBattery = (!detected && nearPack) || (detected && learnHold);
    selState_nxt = selState_r;
    bbmCnt_nxt = 12'h000;
    srcNxt = 1'b0;
    packNxt = 1'b1;
    case (selState_r)
      `CPG_ST_BATT:
      begin
        srcNxt = 1'b0;
        packNxt = 1'b1;
        if (goAdapter)
        begin
          selState_nxt = `CPG_ST_TO_AC;
          srcNxt = 1'b0;
          packNxt = 1'b0;
        end
      end
      `CPG_ST_TO_AC:
      begin
        // Both switches stay off for the whole gap.
        srcNxt = 1'b0;
        packNxt = 1'b0;
        bbmCnt_nxt = bbmCnt_r + 12'h001;
        if (bbmCnt_r == BBM_CYC - 12'h001)
        begin
          selState_nxt = `CPG_ST_AC;
          bbmCnt_nxt = 12'h000;
          srcNxt = 1'b1;
        end
      end
      `CPG_ST_AC:
      begin
        srcNxt = 1'b1;
        packNxt = 1'b0;
        if (goBattery)
        begin
          selState_nxt = `CPG_ST_TO_BATT;
          srcNxt = 1'b0;
        end
      end
      `CPG_ST_TO_BATT:
      begin
        srcNxt = 1'b0;
        packNxt = 1'b0;
        bbmCnt_nxt = bbmCnt_r + 12'h001;
        if (bbmCnt_r == BBM_CYC - 12'h001)
        begin
          selState_nxt = `CPG_ST_BATT;
          bbmCnt_nxt = 12'h000;
          packNxt = 1'b1;
        end
      end
      default:
      begin
        // An illegal code falls back to the safe battery path.
        selState_nxt = `CPG_ST_BATT;
      end
    endcase
  end

  // Selector registers; reset leaves the pack feeding the system.
  always @(posedge mclk)
  begin
    if (srst)
    begin
      selState_r <= `CPG_ST_BATT;
      bbmCnt_r <= 12'h000;
      sourceSwitchGate_r <= 1'b0;
      packSwitchGate_r <= 1'b1;
    end
    else
    begin
      selState_r <= selState_nxt;
      bbmCnt_r <= bbmCnt_nxt;
      sourceSwitchGate_r <= srcNxt;
      packSwitchGate_r <= packNxt;
    end
  end

  // Adapter-good status follows the qualified adapter with a healthy margin.
  always @(posedge mclk)
  begin
    if (srst)
      adapterGood_r <= 1'b0;
    else
      adapterGood_r <= qualified_r && supplyOk;
  end

  // Charge is allowed only with a qualified adapter and learn low.
  wire chargeAllowed = chargeReq && qualified_r && supplyOk && !learn;

  // Soft-start step index and step timer.
  reg [3:0] ssStep_r; // Zero while disabled, then 1 to 8.
  reg [19:0] ssCnt_r;

  // Every enable restarts the ramp from the first step.
  always @(posedge mclk)
  begin
    if (srst)
    begin
      chargeOn_r <= 1'b0;
      ssStep_r <= 4'h0;
      ssCnt_r <= 20'h00000;
    end
    else if (!chargeAllowed)
    begin
      chargeOn_r <= 1'b0;
      ssStep_r <= 4'h0;
      ssCnt_r <= 20'h00000;
    end
    else if (!chargeOn_r)
    begin
      chargeOn_r <= 1'b1;
      ssStep_r <= 4'h1;
      ssCnt_r <= 20'h00000;
    end
    else if (ssStep_r != SS_LAST)
    begin
      // Each step is held for its full time before the next one.
      if (ssCnt_r == STEP_LAST)
      begin
        ssStep_r <= ssStep_r + 4'h1;
        ssCnt_r <= 20'h00000;
      end
      else
        ssCnt_r <= ssCnt_r + 20'h00001;
    end
  end

  // Target is the programmed current scaled by step / 8.
  wire [11:0] ssProduct = chargeCurrentProg * ssStep_r;

  // The target register trails the step by one cycle; the regulation loop is slow.
  always @(posedge mclk)
  begin
    if (srst)
      chargeTarget_r <= 8'h00;
    else
      chargeTarget_r <= ssProduct[10:3];
  end

  // Sync mode with hysteresis: leave below the falling trip, return above the rising one.
  always @(posedge mclk)
  begin
    if (srst)
      syncMode_r <= 1'b0;
    else if (!chargeOn_r)
      syncMode_r <= 1'b0;
    else if (syncMode_r && senseFall)
      syncMode_r <= 1'b0;
    else if (!syncMode_r && senseRise)
      syncMode_r <= 1'b1;
  end

  // Buck gates are driven only while charging; the period counter runs regardless.
  cpg_gate_drive uGate
  (
    .mclk(mclk),
    .srst(srst),
    .run(chargeOn_r),
    .syncMode(syncMode_r),
    .bootLow(bootLow),
    .dutyReq(dutyReq),
    .highSideGate_r(highSideGate),
    .lowSideGate_r(lowSideGate)
  );

endmodule

// ---- dv/cpg_far_side.sv ----
/*
 Far-side model: adapter and pack comparators seen by the sequencer.
 Assumes the bench sets adapter and pack state just after a rising edge.
*/
`timescale 1ns/1ns
module cpg_far_side
#(
  // Cycles for the system node to sag after the adapter leaves.
  parameter int DECAY_CYC = 6
)
(
  // Clock.
  input wire logic mclk,
  // Bench commands.
  input wire logic adapterIn,
  input wire logic packLowIn,
  // Comparator levels towards the device.
  output logic detectAbove,
  output logic supplyAbove,
  output logic nearPack,
  output logic packLow
);
  // Cycles since the adapter was removed.
  int gone = 0;

  // Counts the sag; a slow sag keeps the device waiting.
  always @(posedge mclk)
  begin
    gone <= adapterIn ? 0 : gone + 1;
  end

  assign detectAbove = adapterIn;
  assign supplyAbove = adapterIn;
  // The node only nears the pack once the sag has run its course.
  assign nearPack = !adapterIn && (gone >= DECAY_CYC);
  assign packLow = packLowIn;
endmodule

// ---- dv/cpg_seq_props.sv ----
/*
 Checker for the sequencer ports: selector gaps, learn, soft-start, gates.
 Assumes a bind to cpg_sequencer and a 2500-cycle selector gap.
*/
`timescale 1ns/1ns
module cpg_seq_props
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Watched inputs.
  input wire logic learnIn,
  input wire logic [7:0] chargeCurrentProg,
  // Watched outputs.
  input wire logic sourceSwitchGate_r,
  input wire logic packSwitchGate_r,
  input wire logic adapterGood_r,
  input wire logic chargeOn_r,
  input wire logic syncMode_r,
  input wire logic [7:0] chargeTarget_r,
  input wire logic highSideGate,
  input wire logic lowSideGate
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Run lengths; free running because reset disables every check.
  int offCnt = 0;
  int lowRun = 0;
  int highRun = 0;
  int nsCnt = 0;

  // Track idle selector, gate runs and time spent non-synchronous.
  always @(posedge mclk)
  begin
    offCnt <= (sourceSwitchGate_r || packSwitchGate_r) ? 0 : offCnt + 1;
    lowRun <= lowSideGate ? lowRun + 1 : 0;
    highRun <= highSideGate ? highRun + 1 : 0;
    nsCnt <= syncMode_r ? 0 : nsCnt + 1;
  end

  sequence s_hsFell; $fell(highSideGate); endsequence
  sequence s_lowQuiet; !lowSideGate [*8]; endsequence
  sequence s_lsFell; $fell(lowSideGate); endsequence
  sequence s_hsQuiet; !highSideGate [*8]; endsequence

  property p_noShoot; !(sourceSwitchGate_r && packSwitchGate_r); endproperty
  a_noShoot: assert property (p_noShoot) else $error("both path switches on");
  property p_bbmSrc; $rose(sourceSwitchGate_r) |-> offCnt >= 2500; endproperty
  a_bbmSrc: assert property (p_bbmSrc) else $error("source gap short");
  property p_bbmPack; $rose(packSwitchGate_r) |-> offCnt >= 2500; endproperty
  a_bbmPack: assert property (p_bbmPack) else $error("pack gap short");
  property p_xfer;
    $fell(packSwitchGate_r) |-> (adapterGood_r || $past(adapterGood_r));
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer without adapter");
  property p_learn; learnIn [*5] |-> !chargeOn_r; endproperty
  a_learn: assert property (p_learn) else $error("charging in learn");
  property p_ssFirst;
    $rose(chargeOn_r) |=> (chargeTarget_r == (chargeCurrentProg >> 3));
  endproperty
  a_ssFirst: assert property (p_ssFirst) else $error("first step wrong");
  property p_excl; !(highSideGate && lowSideGate); endproperty
  a_excl: assert property (p_excl) else $error("both gates on");
  property p_deadHL; s_hsFell |-> s_lowQuiet; endproperty
  a_deadHL: assert property (p_deadHL) else $error("dead time after high");
  property p_deadLH; s_lsFell |-> s_hsQuiet; endproperty
  a_deadLH: assert property (p_deadLH) else $error("dead time after low");
  property p_pulse; s_lsFell and (nsCnt > 1700) |-> lowRun <= 20; endproperty
  a_pulse: assert property (p_pulse) else $error("recharge pulse long");
  property p_duty; highSideGate |-> highRun < 832; endproperty
  a_duty: assert property (p_duty) else $error("high side duty unclipped");
endmodule

// ---- dv/cpg_sequencer_tb_top.sv ----
/*
 Bench for the charger sequencer: selector table, qualify timing,
 soft-start steps and per-period gate counts.
 Assumes shortened qualify and step counts; the selector gap stays 2500.
*/
`timescale 1ns/1ns
module cpg_sequencer_tb_top;
  localparam int QUAL = 50;
  localparam int STEP = 20;
  // Pins and far-side commands, all set at time zero.
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic adapter = 1'b0;
  logic packLowCmd = 1'b0;
  logic learnIn = 1'b0;
  logic chargeEnableReq = 1'b1;
  logic bootCapLow = 1'b0;
  logic belowFall = 1'b1;
  logic aboveRise = 1'b0;
  logic [9:0] dutyReq = 10'h064;
  logic [7:0] prog = 8'hc8;
  wire det, sup, near, pkLow, src, pk, good, chg, sync, hs, ls;
  wire [7:0] tgt;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int hi;
  int lo;
  // Adapter, learn, pack low; then source, pack, charging.
  logic [5:0] selRow [7] = '{6'h25, 6'h32, 6'h3c, 6'h32, 6'h25, 6'h02, 6'h25};
  // Below, above, boot low, duty; then high and low cycles per period, sync mode.
  logic [33:0] gateRow [6] = '{{3'h4, 10'h064, 10'h064, 10'h014, 1'b0},
    {3'h2, 10'h064, 10'h064, 10'h2cd, 1'b1}, {3'h0, 10'h064, 10'h064, 10'h2cd, 1'b1},
    {3'h5, 10'h064, 10'h000, 10'h014, 1'b0}, {3'h4, 10'h3ff, 10'h340, 10'h000, 1'b0},
    {3'h0, 10'h3ff, 10'h340, 10'h000, 1'b0}};

  cpg_far_side #(.DECAY_CYC(120)) cpg_far_side_i
  (
    .mclk(mclk), .adapterIn(adapter), .packLowIn(packLowCmd),
    .detectAbove(det), .supplyAbove(sup), .nearPack(near), .packLow(pkLow)
  );

  cpg_sequencer #(.QUALIFY_CYC(QUAL), .STEP_CYC(STEP)) cpg_sequencer_i
  (
    .mclk(mclk), .srst(srst), .sourceDetectAbove(det), .supplyAbovePack(sup),
    .senseLowNearPack(near), .learnIn(learnIn), .packBelowCellMin(pkLow),
    .chargeEnableReq(chargeEnableReq), .bootCapLow(bootCapLow),
    .chargeSenseBelowFall(belowFall), .chargeSenseAboveRise(aboveRise),
    .dutyReq(dutyReq), .chargeCurrentProg(prog), .sourceSwitchGate_r(src),
    .packSwitchGate_r(pk), .adapterGood_r(good), .chargeOn_r(chg),
    .syncMode_r(sync), .chargeTarget_r(tgt), .highSideGate(hs), .lowSideGate(ls)
  );

  always #2 mclk = ~mclk;

  // Cuts a hang short; the whole run needs about 44300 cycles.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count = err_count + 1;
      end_sim();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask

  // Counts gate-on cycles over n cycles, sampled mid-cycle.
  task automatic count(input int n);
    hi = 0;
    lo = 0;
    repeat (n)
    begin
      @(negedge mclk);
      hi += int'(hs === 1'b1);
      lo += int'(ls === 1'b1);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    cmp({1'b0, good, sync, hs, ls, src, pk, chg, tgt}, 16'h0200);
    // A short detect drop must restart the qualify wait.
    @(posedge mclk);
    adapter <= 1'b1;
    repeat (40) @(posedge mclk);
    adapter <= 1'b0;
    repeat (3) @(posedge mclk);
    adapter <= 1'b1;
    repeat (45) @(negedge mclk);
    cmp({14'h0000, src, pk}, 16'h0001);
    repeat (15) @(negedge mclk);
    cmp({14'h0000, src, pk}, 16'h0000);
    repeat (2480) @(negedge mclk);
    cmp({14'h0000, src, pk}, 16'h0000);
    repeat (20) @(negedge mclk);
    cmp({14'h0000, src, pk}, 16'h0002);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge mclk);
      {adapter, learnIn, packLowCmd} <= selRow[i][5:3];
      repeat (2700) @(negedge mclk);
      cmp({13'h0000, src, pk, chg}, {13'h0000, selRow[i][2:0]});
      // Adapter-good follows a qualified adapter whatever the learn state.
      cmp({15'h0000, good}, {15'h0000, selRow[i][5]});
    end
    // Re-enabling charge must restart the ramp from the first step.
    @(posedge mclk);
    chargeEnableReq <= 1'b0;
    repeat (20) @(negedge mclk);
    cmp({7'h00, chg, tgt}, 16'h0000);
    @(posedge mclk);
    chargeEnableReq <= 1'b1;
    for (int i = 0; i < 10 && chg !== 1'b1; i++)
      @(negedge mclk);
    repeat (STEP / 2) @(negedge mclk);
    for (int k = 1; k <= 8; k++)
    begin
      cmp({8'h00, tgt}, 16'((32'(prog) * k) >> 3));
      repeat (STEP) @(negedge mclk);
    end
    repeat (STEP * 2) @(negedge mclk);
    cmp({8'h00, tgt}, {8'h00, prog});
    // Any 833-cycle window holds exactly one switching period.
    for (int i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      {belowFall, aboveRise, bootCapLow, dutyReq} <= gateRow[i][33:21];
      repeat (1666) @(negedge mclk);
      count(833);
      cmp(16'(hi), {6'h00, gateRow[i][20:11]});
      cmp(16'(lo), {6'h00, gateRow[i][10:1]});
      cmp({15'h0000, sync}, {15'h0000, gateRow[i][0]});
    end
    // Weak bootstrap at full duty in sync mode must force a refresh.
    @(posedge mclk);
    {belowFall, aboveRise, bootCapLow} <= 3'h3;
    repeat (1666) @(negedge mclk);
    count(5831);
    cmp(16'(lo != 0), 16'h0001);
    cmp({15'h0000, sync}, 16'h0001);
    // A reset in mid-run must put the pack back on the system at once.
    @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    cmp({1'b0, good, sync, hs, ls, src, pk, chg, tgt}, 16'h0200);
    // The adapter is still present, so the qualify wait and the gap start again.
    repeat (60) @(negedge mclk);
    cmp({14'h0000, src, pk}, 16'h0000);
    end_sim();
  end
endmodule

bind cpg_sequencer cpg_seq_props cpg_seq_props_i
(
  .mclk(mclk), .srst(srst), .learnIn(learnIn), .chargeCurrentProg(chargeCurrentProg),
  .sourceSwitchGate_r(sourceSwitchGate_r), .packSwitchGate_r(packSwitchGate_r),
  .adapterGood_r(adapterGood_r), .chargeOn_r(chargeOn_r), .syncMode_r(syncMode_r),
  .chargeTarget_r(chargeTarget_r), .highSideGate(highSideGate), .lowSideGate(lowSideGate)
);
